// >>> core/bst_tap.sv
// boundary-scan test access port with its pin ring and core hand-off
//
// Operation
// - sample tms and tdi on rising test clock
// - tdo changes on falling edge, driven only shifting
// - unconnected tms and tdi read as one
// - tdi enters msb, tdo leaves from lsb
// - instruction selects exactly one register in path
// - five edges of tms high reset controller
// - test reset leaves memory operation untouched
// - power-up reset floats tdo
// - three-bit instruction register, loads only when selected
// - instruction becomes identification code on reset
// - capture-ir loads binary 01 into low bits
// - one-bit bypass register, cleared when executed
// - boundary register captures pins, shifts in shift-dr
// - one boundary cell per package bump
// - extest, sample and sample-z capture pin ring
// - identification instruction captures and shifts fixed code
// - standard sixteen-state controller steered by tms
// - new instruction takes effect at update-ir
// - sample-z floats read bus until next update-ir or test reset
// - cell 108 enables read bus, preset high
// - extest drives preloaded cells onto output pins
module bst_tap #(
    parameter int BSR_LEN = bst_pkg::BSR_LEN_DEF,
    parameter logic [bst_pkg::ID_W-1:0] ID_CODE = bst_pkg::ID_CODE_DEF
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_LEN-1:0] pin_state_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    output logic [BSR_LEN-1:0] pin_drive_o,
    output logic test_drive_o,
    output logic q_hiz_o
);
    import bst_pkg::*;

    // *****************************************************************
    // helpers
    // *****************************************************************

    // reserved opcodes fall back to bypass so no undefined mode exists
    function automatic bst_sel_e sel_of(input logic [IR_W-1:0] op);
        bst_sel_e s;
        s = SEL_BYP;
        if (op == OP_IDCODE) begin
            s = SEL_ID;
        end else if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_SAMPLE_Z) begin
            s = SEL_BSR;
        end
        return s;
    endfunction

    // boundary update stage after reset: only the enable cell is high
    function automatic logic [BSR_LEN-1:0] bsr_reset_val();
        logic [BSR_LEN-1:0] v;
        v = '0;
        v[OE_CELL] = 1'b1;
        return v;
    endfunction

    // the given data register sits in the path during capture-dr;
    // shared by the bypass, identification and boundary stages
    function automatic logic dr_cap(input bst_sel_e cur, input bst_sel_e want,
        input bst_state_e st);
        return (cur == want) && (st == ST_CAP_DR);
    endfunction

    // the given data register sits in the path during shift-dr;
    // shared by the bypass, identification and boundary stages
    function automatic logic dr_shift(input bst_sel_e cur, input bst_sel_e want,
        input bst_state_e st);
        return (cur == want) && (st == ST_SHIFT_DR);
    endfunction

    // run counter for the five-edge reset guard; wide enough to hold one
    // less than the reset count
    localparam int RUN_W = $clog2(TMS_RESET_EDGES);
    localparam logic [RUN_W-1:0] RUN_LAST = RUN_W'(TMS_RESET_EDGES - 1);
    localparam logic [RUN_W-1:0] RUN_ONE = RUN_W'(1);

    // *****************************************************************
    // test clock domain
    // *****************************************************************

    logic rst_meta_reg;
    logic rst_sync_reg;
    bst_state_e state_reg;
    bst_state_e state_next;
    logic [IR_W-1:0] ir_shift_reg;
    logic [IR_W-1:0] ir_reg;
    logic byp_reg;
    logic [ID_W-1:0] id_shift_reg;
    logic [BSR_LEN-1:0] bsr_shift_reg;
    logic [BSR_LEN-1:0] bsr_upd_reg;
    logic [BSR_LEN-1:0] pin_meta_reg;
    logic [BSR_LEN-1:0] pin_sync_reg;
    logic upd_tgl_reg;
    bst_sel_e sel;
    logic [RUN_W-1:0] tms_run_reg;

    assign sel = sel_of(ir_reg);

    // system reset into the test clock domain; the power-up reset of the
    // controller needs a few test clock edges, or five tms-high edges
    always_ff @(posedge tck_i) begin
        rst_meta_reg <= reset_i;
        rst_sync_reg <= rst_meta_reg;
    end

    // pin ring sampled through two stages; a pin moving at capture
    // time gives an arbitrary but settled value
    always_ff @(posedge tck_i) begin
        pin_meta_reg <= pin_state_i;
        pin_sync_reg <= pin_meta_reg;
    end

    // controller next state; pads pull unconnected tms high
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RESET: begin
                state_next = tms_i ? ST_RESET : ST_IDLE;
            end
            ST_IDLE: begin
                state_next = tms_i ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_DR: begin
                state_next = tms_i ? ST_SEL_IR : ST_CAP_DR;
            end
            ST_CAP_DR: begin
                state_next = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_SHIFT_DR: begin
                state_next = tms_i ? ST_EXIT1_DR : ST_SHIFT_DR;
            end
            ST_EXIT1_DR: begin
                state_next = tms_i ? ST_UPD_DR : ST_PAUSE_DR;
            end
            ST_PAUSE_DR: begin
                state_next = tms_i ? ST_EXIT2_DR : ST_PAUSE_DR;
            end
            ST_EXIT2_DR: begin
                state_next = tms_i ? ST_UPD_DR : ST_SHIFT_DR;
            end
            ST_UPD_DR: begin
                state_next = tms_i ? ST_SEL_DR : ST_IDLE;
            end
            ST_SEL_IR: begin
                state_next = tms_i ? ST_RESET : ST_CAP_IR;
            end
            ST_CAP_IR: begin
                state_next = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_SHIFT_IR: begin
                state_next = tms_i ? ST_EXIT1_IR : ST_SHIFT_IR;
            end
            ST_EXIT1_IR: begin
                state_next = tms_i ? ST_UPD_IR : ST_PAUSE_IR;
            end
            ST_PAUSE_IR: begin
                state_next = tms_i ? ST_EXIT2_IR : ST_PAUSE_IR;
            end
            ST_EXIT2_IR: begin
                state_next = tms_i ? ST_UPD_IR : ST_SHIFT_IR;
            end
            ST_UPD_IR: begin
                state_next = tms_i ? ST_SEL_DR : ST_IDLE;
            end
            default: begin
                state_next = ST_RESET;
            end
        endcase

        // fifth tms-high edge in a row always ends in reset
        if (tms_i && tms_run_reg == RUN_LAST) begin
            state_next = ST_RESET;
        end
    end

    // controller state, moved only on rising test clock;
    // the synced system reset has priority over tms
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            state_reg <= ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // consecutive tms-high edges seen, saturating one short of the reset
    // count; this guard lands in reset on the fifth edge whatever the
    // controller code was, so a disturbed state cannot lock the port out
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg || !tms_i) begin
            tms_run_reg <= '0;
        end else if (tms_run_reg != RUN_LAST) begin
            tms_run_reg <= tms_run_reg + RUN_ONE;
        end
    end

    // instruction shift stage, touched only while it is in the path
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            ir_shift_reg <= IR_CAPTURE_VAL;
        end else if (state_reg == ST_CAP_IR) begin
            ir_shift_reg <= IR_CAPTURE_VAL;
        end else if (state_reg == ST_SHIFT_IR) begin
            ir_shift_reg <= {tdi_i, ir_shift_reg[IR_W-1:1]};
        end
    end

    // current instruction; changes only at update-ir or reset; it is
    // reset on the edge that enters reset, together with the core event
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg || state_next == ST_RESET) begin
            ir_reg <= OP_IDCODE;
        end else if (state_reg == ST_UPD_IR) begin
            ir_reg <= ir_shift_reg;
        end
    end

    // bypass cell: zero at capture, then passes tdi along;
    // a zero first tells the tester the chain length
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            byp_reg <= 1'b0;
        end else if (dr_cap(sel, SEL_BYP, state_reg)) begin
            byp_reg <= 1'b0;
        end else if (dr_shift(sel, SEL_BYP, state_reg)) begin
            byp_reg <= tdi_i;
        end
    end

    // identification word, loaded from fixed wiring at capture
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            id_shift_reg <= ID_CODE;
        end else if (dr_cap(sel, SEL_ID, state_reg)) begin
            id_shift_reg <= ID_CODE;
        end else if (dr_shift(sel, SEL_ID, state_reg)) begin
            id_shift_reg <= {tdi_i, id_shift_reg[ID_W-1:1]};
        end
    end

    // boundary shift stage, one cell per bump, no-connect cells included
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            bsr_shift_reg <= '0;
        end else if (dr_cap(sel, SEL_BSR, state_reg)) begin
            bsr_shift_reg <= pin_sync_reg;
        end else if (dr_shift(sel, SEL_BSR, state_reg)) begin
            bsr_shift_reg <= {tdi_i, bsr_shift_reg[BSR_LEN-1:1]};
        end
    end

    // boundary update stage holds preload values for extest; preset on the
    // edge that enters reset so the core event carries the preset values
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg || state_next == ST_RESET) begin
            bsr_upd_reg <= bsr_reset_val();
        end else if (sel == SEL_BSR && state_reg == ST_UPD_DR) begin
            bsr_upd_reg <= bsr_shift_reg;
        end
    end

    // entry into reset is an event too, so extest is dropped at once
    // event toggle for the core side; data changes on the same edge
    // but is read there only after the two-stage toggle sync
    always_ff @(posedge tck_i) begin
        if (rst_sync_reg) begin
            upd_tgl_reg <= 1'b0;
        end else if (state_reg == ST_UPD_DR || state_reg == ST_UPD_IR) begin
            upd_tgl_reg <= ~upd_tgl_reg;
        end else if (state_next == ST_RESET && state_reg != ST_RESET) begin
            upd_tgl_reg <= ~upd_tgl_reg;
        end
    end

    // serial output on the falling edge; floated outside shift states
    // the far end then gets half a period of setup before it samples
    always_ff @(negedge tck_i) begin
        if (rst_sync_reg) begin
            tdo_oe_o <= 1'b0;
            tdo_o <= 1'b0;
        end else begin
            tdo_oe_o <= (state_reg == ST_SHIFT_IR) || (state_reg == ST_SHIFT_DR);
            if (state_reg == ST_SHIFT_IR) begin
                tdo_o <= ir_shift_reg[0];
            end else if (sel == SEL_ID) begin
                tdo_o <= id_shift_reg[0];
            end else if (sel == SEL_BSR) begin
                tdo_o <= bsr_shift_reg[0];
            end else begin
                tdo_o <= byp_reg;
            end
        end
    end

    // *****************************************************************
    // core clock domain
    // *****************************************************************

    logic tgl_meta_reg;
    logic tgl_sync_reg;
    logic tgl_last_reg;

    // toggle crossing; the memory path itself never sees test reset
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            tgl_meta_reg <= 1'b0;
            tgl_sync_reg <= 1'b0;
            tgl_last_reg <= 1'b0;
        end else begin
            tgl_meta_reg <= upd_tgl_reg;
            tgl_sync_reg <= tgl_meta_reg;
            tgl_last_reg <= tgl_sync_reg;
        end
    end

    // test overrides for the pin ring, taken whole on each update event
    // a vector that changes only on events keeps the pins free of mixes
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            pin_drive_o <= bsr_reset_val();
            test_drive_o <= 1'b0;
            q_hiz_o <= 1'b0;
        end else if (tgl_sync_reg != tgl_last_reg) begin
            pin_drive_o <= bsr_upd_reg;
            test_drive_o <= (ir_reg == OP_EXTEST);
            q_hiz_o <= (ir_reg == OP_SAMPLE_Z) ||
                ((ir_reg == OP_EXTEST) && !bsr_upd_reg[OE_CELL]);
        end
    end

endmodule // bst_tap

// >>> core/bst_pkg.sv
// shared constants and types of the boundary-scan test access port
package bst_pkg;

    // *****************************************************************
    // register widths and opcodes
    // *****************************************************************
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_LEN_DEF = 109;
    localparam int OE_CELL = 108;
    localparam int TMS_RESET_EDGES = 5;

    // instruction codes; three codes stay reserved
    localparam logic [IR_W-1:0] OP_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] OP_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] OP_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] OP_BYPASS = 3'h7;

    // fixed pattern loaded into the instruction shift stage at capture
    localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

    // identification word; the value is arbitrary
    localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0a5c_3001;

    // *****************************************************************
    // controller states, one-hot
    // *****************************************************************
    typedef enum logic [15:0] {
        ST_RESET = 16'h0001,
        ST_IDLE = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHIFT_DR = 16'h0010,
        ST_EXIT1_DR = 16'h0020,
        ST_PAUSE_DR = 16'h0040,
        ST_EXIT2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHIFT_IR = 16'h0800,
        ST_EXIT1_IR = 16'h1000,
        ST_PAUSE_IR = 16'h2000,
        ST_EXIT2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } bst_state_e;

    // data register placed in the serial path
    typedef enum logic [1:0] {
        SEL_BYP = 2'h0,
        SEL_ID = 2'h1,
        SEL_BSR = 2'h2
    } bst_sel_e;

endpackage

// >>> testbench/bst_tap_sva.sv
// assertion checker for the boundary-scan test port
module bst_tap_sva
    import bst_pkg::*;
#(
    parameter int BSR_LEN = BSR_LEN_DEF
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [BSR_LEN-1:0] pin_state_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic [BSR_LEN-1:0] pin_drive_o,
    input wire logic test_drive_o,
    input wire logic q_hiz_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********
    // checks
    // ********
    localparam logic [BSR_LEN-1:0] OE_SEL = BSR_LEN'(1) << OE_CELL;

    // tck high on two core samples means no falling edge came between
    chk_tdo_fall_only: assert property (@(posedge core_clk_i) disable iff (reset_i)
        tck_i && $past(tck_i) |-> $stable(tdo_o) && $stable(tdo_oe_o))
        else $error("tdo moved while tck high");
    // two tck rises leave the core ample time to see the reset event
    chk_tms_reset: assert property (@(posedge tck_i) disable iff (reset_i)
        tms_i [*5] |-> ##2 (!test_drive_o && !q_hiz_o && pin_drive_o == OE_SEL))
        else $error("tms reset left overrides active");
    chk_oe_leave: assert property (@(posedge tck_i) disable iff (reset_i)
        tms_i |=> !tdo_oe_o) else $error("tdo driven outside shift");
    chk_oe_hold: assert property (@(posedge tck_i) disable iff (reset_i)
        tdo_oe_o && !tms_i |=> tdo_oe_o) else $error("tdo released inside shift");
    chk_oe_cause: assert property (@(posedge tck_i) disable iff (reset_i)
        $rose(tdo_oe_o) |-> !$past(tms_i)) else $error("shift entered with tms high");
    // reset itself is the cause here, so it cannot disable the check
    chk_por_float: assert property (@(posedge tck_i)
        reset_i [*4] |=> !tdo_oe_o) else $error("tdo driven in reset");
    chk_extest_float: assert property (@(posedge core_clk_i) disable iff (reset_i)
        test_drive_o |-> q_hiz_o == !pin_drive_o[OE_CELL])
        else $error("read bus float not from cell");
    chk_idle_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !tck_i [*5] |-> $stable(pin_drive_o) && $stable(test_drive_o) && $stable(q_hiz_o))
        else $error("core outputs moved with tck still");

    cover property (@(posedge core_clk_i) $rose(test_drive_o));
    cover property (@(posedge core_clk_i) $rose(q_hiz_o));
    cover property (@(posedge tck_i) $rose(tdo_oe_o));
endmodule // bst_tap_sva

bind bst_tap bst_tap_sva #(.BSR_LEN(BSR_LEN)) i_sva (.core_clk_i, .reset_i, .tck_i, .tms_i,
    .tdi_i, .pin_state_i, .tdo_o, .tdo_oe_o, .pin_drive_o, .test_drive_o, .q_hiz_o);

// >>> testbench/bst_ctl.sv
// test controller model standing on the far side of the test port
module bst_ctl (
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl_last = 1'b0;

    // tck rests low between frames, tms and tdi at their pull-up level
    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end

    // one 125 ns period; a released tdo shows no stale bit
    task automatic clk(input logic t, input logic d, output logic o);
        tms_o = t;
        tdi_o = d;
        #31.25;
        o = tdo_oe_i ? tdo_i : ~lvl_last;
        lvl_last = o;
        tck_o = 1'b1;
        #62.5;
        tck_o = 1'b0;
        #31.25;
    endtask

    // tms bits sent lsb first
    task automatic tms_seq(input logic [7:0] seq, input int n);
        logic o;
        for (int i = 0; i < n; i++) begin
            clk(seq[i], 1'b1, o);
        end
    endtask

    // from idle: shift n bits through ir or dr, then update and back to idle
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
        output logic [127:0] dout);
        logic o;
        dout = '0;
        tms_seq(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
        for (int i = 0; i < n; i++) begin
            clk(i == n - 1, din[i], o);
            dout[i] = o;
        end
        tms_seq(8'h01, 2);
    endtask
endmodule // bst_ctl

// >>> testbench/testbench.sv
// self-checking bench for the boundary-scan test port
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bst_pkg::*;
    localparam int N = 120;
    localparam logic [127:0] PAT = 128'h5a3c_0f96_e1d2_7b48_36c9_a5f0_1e87_d42b;
    typedef struct {logic [2:0] op; int len; logic td; logic hz;} bst_row_s;
    // opcode, expected path length, expected drive and float flags
    bst_row_s rows [8] = '{'{OP_IDCODE, ID_W, 1'b0, 1'b0}, '{OP_BYPASS, 1, 1'b0, 1'b0},
        '{3'h3, 1, 1'b0, 1'b0}, '{3'h5, 1, 1'b0, 1'b0}, '{3'h6, 1, 1'b0, 1'b0},
        '{OP_SAMPLE, BSR_LEN_DEF, 1'b0, 1'b0}, '{OP_SAMPLE_Z, BSR_LEN_DEF, 1'b0, 1'b1},
        '{OP_EXTEST, BSR_LEN_DEF, 1'b1, 1'b1}};
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic tck, tms, tdi, tdo, tdo_oe, test_drive, q_hiz;
    logic [BSR_LEN_DEF-1:0] pin_state = '0;
    logic [BSR_LEN_DEF-1:0] pin_drive;
    logic [BSR_LEN_DEF-1:0] exp_drv = BSR_LEN_DEF'(1) << OE_CELL;
    logic [127:0] dout, cap;
    int miscompares = 0;
    int cmp_count = 0;

    bst_tap i_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .tck_i(tck), .tms_i(tms),
        .tdi_i(tdi), .pin_state_i(pin_state), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
        .pin_drive_o(pin_drive), .test_drive_o(test_drive), .q_hiz_o(q_hiz));
    bst_ctl i_ctl (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo), .tdo_oe_i(tdo_oe));

    // 50 MHz core clock
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // captured bits leave first, then the pattern delayed by the path length
    function automatic logic [127:0] path(input int len, input logic [127:0] c);
        logic [127:0] r;
        r = '0;
        for (int i = 0; i < N; i++) begin
            r[i] = (i < len) ? c[i] : PAT[i - len];
        end
        return r;
    endfunction

    // reset is stretched so the tck side sees enough edges to sync it
    initial begin
        pin_state <= ~PAT[BSR_LEN_DEF-1:0];
        fork
            i_ctl.tms_seq(8'hff, 8);
            repeat (32) @(posedge core_clk_i);
        join
        chk(128'({pin_drive, test_drive, q_hiz, tdo_oe}), 128'({exp_drv, 3'b000}));
        @(posedge core_clk_i);
        reset_i <= 1'b0;
        i_ctl.tms_seq(8'h07, 4);
        foreach (rows[k]) begin
            i_ctl.scan(1'b1, IR_W, 128'(rows[k].op), cap);
            chk(cap, 128'(IR_CAPTURE_VAL));
            cap = rows[k].len == 1 ? '0 : rows[k].len == ID_W ? 128'(ID_CODE_DEF) : 128'(pin_state);
            i_ctl.scan(1'b0, N, PAT, dout);
            chk(dout, path(rows[k].len, cap));
            if (rows[k].len == BSR_LEN_DEF) begin
                exp_drv = PAT[N-1 -: BSR_LEN_DEF];
            end
            repeat (6) @(posedge core_clk_i);
            chk(128'({pin_drive, test_drive, q_hiz}), 128'({exp_drv, rows[k].td, rows[k].hz}));
        end
        // five tms-high edges out of extest restore all reset defaults
        i_ctl.tms_seq(8'h1f, 6);
        exp_drv = BSR_LEN_DEF'(1) << OE_CELL;
        repeat (6) @(posedge core_clk_i);
        chk(128'({pin_drive, test_drive, q_hiz, tdo_oe}), 128'({exp_drv, 3'b000}));
        i_ctl.scan(1'b0, N, PAT, dout);
        chk(dout, path(ID_W, 128'(ID_CODE_DEF)));
        test_done();
    end

    // the whole run needs about 150 us
    initial begin
        #400_000;
        miscompares++;
        test_done();
    end
endmodule // testbench
